// ---- gst_map.svh ----
// Notes on behaviour
// - 16-bit count, bytes writable, write is immediate
// - run bit off stops; gate qualifies when enabled
// - source field picks instruction, system, external, capsense
// - system clock gives four counts per instruction
// - external source counts on rising edges
// - external source synchronised or asynchronous
// - falling edge needed before first counted rise
// - prescaler divides by 1, 2, 4, 8
// - prescaler hidden, cleared by count writes
// - crystal oscillator runs when enabled, also asleep
// - bypass bit skips the resynchronising stage
// - asynchronous external counting continues asleep, wakes
// - mode switch may skip or add one count
// - byte reads are always coherent
// - gate enable and gate polarity controls
// - gated count only when gate equals polarity
// - blocked gate holds count unchanged
// - rollover sets sticky overflow flag
// - gate source field selects four gate signals
// - special event clears count, write wins
`ifndef GST_MAP_SVH
`define GST_MAP_SVH

// =====================================================================
// register byte offsets
`define GST_OFF_CTRL       12'h000
`define GST_OFF_GATE       12'h004
`define GST_OFF_COUNT_LOW  12'h008
`define GST_OFF_COUNT_HIGH 12'h00c
`define GST_OFF_STATUS     12'h010

// =====================================================================
// field positions and reset values
`define GST_STATUS_OVF_BIT 0
`define GST_CTRL_RESET     8'h00
`define GST_GATE_RESET     8'h00
`define GST_COUNT_RESET    16'h0000
`define GST_CTRL_WMASK     8'hfd
`define GST_GATE_WMASK     8'hc3

// =====================================================================
// timing: instruction cycle is four system clocks
`define GST_INSTR_DIV      4

`endif

// ---- gst_pkg.sv ----
// =====================================================================
// shared types of the gated timer
package gst_pkg;

  typedef enum logic [1:0] {
    GST_SRC_INSTR = 2'b00,
    GST_SRC_SYS   = 2'b01,
    GST_SRC_EXT   = 2'b10,
    GST_SRC_CAP   = 2'b11
  } gst_src_t;

  typedef enum logic [1:0] {
    GST_GATE_PIN  = 2'b00,
    GST_GATE_TOVF = 2'b01,
    GST_GATE_CMP1 = 2'b10,
    GST_GATE_CMP2 = 2'b11
  } gst_gsrc_t;

  typedef struct packed {
    gst_src_t   clock_source_select;
    logic [1:0] prescale_select;
    logic       crystal_osc_enable;
    logic       sync_bypass;
    logic       rsvd;
    logic       counter_run;
  } gst_ctrl_t;

  typedef struct packed {
    logic       gate_enable;
    logic       gate_polarity;
    logic [3:0] rsvd;
    gst_gsrc_t  gate_source_select;
  } gst_gate_t;

endpackage

// ---- gst_prescaler.sv ----
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// divide-by-1/2/4/8 prescaler, never visible to software
module gst_prescaler
  import gst_pkg::*;
#(
  parameter int PS_W = 3
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic       tick,
  input  wire logic [1:0] sel,
  output logic            pulse
);

  initial begin
    if (PS_W < 3) $error("prescaler needs at least three bits");
  end

  logic [PS_W-1:0] cnt_q;
  logic [PS_W-1:0] cnt_d;
  logic [PS_W-1:0] mask;

  // mask of low bits that must be all ones to pass a tick
  always_comb begin
    case (sel)
      2'b00:   mask = PS_W'(0);
      2'b01:   mask = PS_W'(1);
      2'b10:   mask = PS_W'(3);
      default: mask = PS_W'(7);
    endcase
    pulse = tick & ((cnt_q & mask) == mask);
    cnt_d = cnt_q;
    if (clear) begin
      cnt_d = '0;
    end else if (tick) begin
      cnt_d = (cnt_q & mask) == mask ? '0 : cnt_q + PS_W'(1);
    end
  end

  // prescale state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  a_presc_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clear |=> cnt_q == '0)
    else $error("prescaler not cleared by count write");

endmodule
`default_nettype wire

// ---- gst_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "gst_map.svh"
// =====================================================================
// gated 16-bit timer/counter with apb register access
module gst_timer
  import gst_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_count_input,
  input  wire logic        cap_sense_osc,
  input  wire logic        crystal_in,
  output logic             crystal_out,
  output logic             crystal_osc_run,
  input  wire logic        gate_input,
  input  wire logic        other_timer_overflow,
  input  wire logic        comparator1_out,
  input  wire logic        comparator2_out,
  input  wire logic        special_event,
  input  wire logic        sleep_mode,
  output logic             overflow_flag,
  output logic             wake_request
);

  initial begin
    if (COUNT_W != 16) $error("counter is built from two bytes");
  end

  // =====================================================================
  // apb decode
  logic            setup;
  logic            access;
  logic            wr;
  logic            mapped;
  logic            wr_ctrl;
  logic            wr_gate;
  logic            wr_low;
  logic            wr_high;
  logic            wr_stat;
  logic            count_wr;
  logic [7:0]      wbyte;

  // zero wait state slave; an unmapped address is refused with pslverr
  always_comb begin
    setup   = psel & ~penable;
    access  = psel & penable;
    mapped  = paddr == `GST_OFF_CTRL || paddr == `GST_OFF_GATE ||
              paddr == `GST_OFF_COUNT_LOW ||
              paddr == `GST_OFF_COUNT_HIGH || paddr == `GST_OFF_STATUS;
    pready  = 1'b1;
    pslverr = access & ~mapped;
    wr      = access & pwrite & pstrb[0];
    wbyte   = pwdata[7:0];
    wr_ctrl = wr & (paddr == `GST_OFF_CTRL);
    wr_gate = wr & (paddr == `GST_OFF_GATE);
    wr_low  = wr & (paddr == `GST_OFF_COUNT_LOW);
    wr_high = wr & (paddr == `GST_OFF_COUNT_HIGH);
    wr_stat = wr & (paddr == `GST_OFF_STATUS);
    count_wr = wr_low | wr_high;
  end

  // =====================================================================
  // control registers
  gst_ctrl_t ctrl_q;
  gst_ctrl_t ctrl_d;
  gst_gate_t gate_q;
  gst_gate_t gate_d;

  // reserved bits are masked so they always read zero
  always_comb begin
    ctrl_d = ctrl_q;
    gate_d = gate_q;
    if (wr_ctrl) begin
      ctrl_d = gst_ctrl_t'(wbyte & `GST_CTRL_WMASK);
    end
    if (wr_gate) begin
      gate_d = gst_gate_t'(wbyte & `GST_GATE_WMASK);
    end
  end

  // control state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= gst_ctrl_t'(`GST_CTRL_RESET);
      gate_q <= gst_gate_t'(`GST_GATE_RESET);
    end else begin
      ctrl_q <= ctrl_d;
      gate_q <= gate_d;
    end
  end

  // =====================================================================
  // clock source selection and edge detection
  logic       src_ext;
  logic       src_level;
  logic       async_ext;
  logic       raw_q;
  logic       rs1_q;
  logic       rs2_q;
  logic       prev_q;
  logic       lvl_now;
  logic       rise;
  logic       fall;
  logic [1:0] div_q;
  logic [1:0] div_d;
  logic       int_tick;
  logic       xo_q;

  // external sources: pin or crystal under 10, capsense under 11
  always_comb begin
    src_ext   = ctrl_q.clock_source_select[1];
    src_level = ctrl_q.clock_source_select == GST_SRC_CAP ? cap_sense_osc :
                ctrl_q.crystal_osc_enable ? crystal_in :
                external_count_input;
    async_ext = src_ext & ctrl_q.sync_bypass;
    // bypass skips the two resync flops; switching modes can drop
    // or repeat one edge, which is accepted behaviour
    lvl_now   = ctrl_q.sync_bypass ? raw_q : rs2_q;
    rise      = lvl_now & ~prev_q;
    fall      = ~lvl_now & prev_q;
    div_d     = div_q + 2'd1;
    int_tick  = ctrl_q.clock_source_select == GST_SRC_SYS ? 1'b1 :
                div_q == 2'(`GST_INSTR_DIV - 1);
  end

  // sampling and resync stages, instruction clock divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_q  <= 1'b0;
      rs1_q  <= 1'b0;
      rs2_q  <= 1'b0;
      prev_q <= 1'b0;
      div_q  <= 2'd0;
      xo_q   <= 1'b0;
    end else begin
      raw_q  <= src_level;
      rs1_q  <= raw_q;
      rs2_q  <= rs1_q;
      prev_q <= lvl_now;
      div_q  <= div_d;
      xo_q   <= ctrl_q.crystal_osc_enable & ~crystal_in;
    end
  end

  // amplifier keeps running whatever sleep_mode says
  assign crystal_osc_run = ctrl_q.crystal_osc_enable;
  assign crystal_out     = xo_q;

  // =====================================================================
  // gate and count enable
  logic gate_sig;
  logic gate_ok;
  logic sleep_ok;
  logic enable;
  logic armed_q;
  logic armed_d;
  logic tick;
  logic presc_pulse;

  always_comb begin
    case (gate_q.gate_source_select)
      GST_GATE_PIN:  gate_sig = gate_input;
      GST_GATE_TOVF: gate_sig = other_timer_overflow;
      GST_GATE_CMP1: gate_sig = comparator1_out;
      default:       gate_sig = comparator2_out;
    endcase
    gate_ok  = ~gate_q.gate_enable |
               (gate_sig == gate_q.gate_polarity);
    sleep_ok = ~sleep_mode | async_ext;
    enable   = ctrl_q.counter_run & gate_ok & sleep_ok;
    // counter mode waits for a falling edge before the first rise
    armed_d  = armed_q;
    if (!ctrl_q.counter_run || count_wr) begin
      armed_d = 1'b0;
    end else if (fall) begin
      armed_d = 1'b1;
    end
    tick = enable & (src_ext ? (rise & armed_q) : int_tick);
  end

  // falling-edge arming flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
    end
  end

  gst_prescaler #(
    .PS_W (3)
  ) u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (count_wr),
    .tick    (tick),
    .sel     (ctrl_q.prescale_select),
    .pulse   (presc_pulse)
  );

  // =====================================================================
  // counter, overflow flag, read data
  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  logic               ovf_set;
  logic               flag_q;
  logic               flag_d;
  logic               wake_q;
  logic [31:0]        rdata_q;
  logic [31:0]        rdata_d;

  // a byte write beats the special event and any increment
  always_comb begin
    ovf_set = 1'b0;
    count_d = count_q;
    if (count_wr) begin
      if (wr_low) count_d[7:0] = wbyte;
      if (wr_high) count_d[15:8] = wbyte;
    end else if (special_event) begin
      count_d = '0;
    end else if (presc_pulse) begin
      count_d = count_q + 16'h0001;
      ovf_set = count_q == 16'hffff;
    end
    // sticky flag: a new overflow wins over a clear
    flag_d = flag_q;
    if (wr_stat && wbyte[`GST_STATUS_OVF_BIT]) flag_d = 1'b0;
    if (ovf_set) flag_d = 1'b1;
    // read data sampled at setup from pclk-domain flops, so a byte
    // can never be torn by a running external clock
    rdata_d = rdata_q;
    if (setup) begin
      case (paddr)
        `GST_OFF_CTRL:       rdata_d = {24'h000000, ctrl_q};
        `GST_OFF_GATE:       rdata_d = {24'h000000, gate_q};
        `GST_OFF_COUNT_LOW:  rdata_d = {24'h000000, count_q[7:0]};
        `GST_OFF_COUNT_HIGH: rdata_d = {24'h000000, count_q[15:8]};
        `GST_OFF_STATUS:     rdata_d = {31'h00000000, flag_q};
        default:             rdata_d = 32'h00000000;
      endcase
    end
  end

  // counter and status registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= `GST_COUNT_RESET;
      flag_q  <= 1'b0;
      wake_q  <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      count_q <= count_d;
      flag_q  <= flag_d;
      wake_q  <= flag_d & sleep_mode;
      rdata_q <= rdata_d;
    end
  end

  assign prdata        = rdata_q;
  assign overflow_flag = flag_q;
  assign wake_request  = wake_q;

  // =====================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic quiet;
  assign quiet = ~count_wr & ~special_event;

  sequence s_sys_setup;
    ctrl_q.counter_run && ctrl_q.clock_source_select == GST_SRC_SYS &&
    ctrl_q.prescale_select == 2'b00 && !gate_q.gate_enable &&
    !sleep_mode && quiet;
  endsequence

  a_low_byte_write: assert property (wr_low |=>
    count_q[7:0] == $past(wbyte))
    else $error("low byte write not applied");

  a_run_off_hold: assert property (!ctrl_q.counter_run && quiet |=>
    count_q == $past(count_q))
    else $error("counter moved while off");

  a_sys_four_rate: assert property (s_sys_setup [*4] |=>
    count_q == $past(count_q, 4) + 16'h0004)
    else $error("system clock rate not four per instruction");

  a_gate_blocks: assert property (gate_q.gate_enable &&
    gate_sig != gate_q.gate_polarity && quiet |=>
    $stable(count_q))
    else $error("count moved with gate closed");

  a_overflow_sets: assert property (ovf_set |=> flag_q)
    else $error("rollover did not set overflow flag");

  a_special_clear: assert property (special_event && !count_wr |=>
    count_q == '0 && !$rose(flag_q))
    else $error("special event clear wrong");

  a_write_disarms: assert property (count_wr ##1 src_ext && !fall |=>
    !armed_q)
    else $error("counter armed without falling edge");

  a_sleep_freeze: assert property (sleep_mode && !async_ext && quiet |=>
    $stable(count_q))
    else $error("counter ran in sleep while synchronous");

endmodule
`default_nettype wire

// ---- gst_ext_src.sv ----
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// far-side count pin: idles low, edges only while a burst is requested
module gst_ext_src (
  input  wire logic pclk,
  output logic      ext_clk
);
  initial ext_clk = 1'b0;

  // four pclk per phase keeps every edge visible through the sync flops
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge pclk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_clk <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- gst_timer_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "gst_map.svh"
// =====================================================================
// bench for the gated timer: apb tasks and scenario sequence
module gst_timer_tb;
  import gst_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready, pslverr, ext_clk, xout, xrun, ovf, wake;
  logic        xin = 1'b0;
  logic        sleep = 1'b0;
  logic        sev = 1'b0;
  logic [3:0]  gsig = 4'h0;
  logic        last_err;
  logic [31:0] rv;
  int          errors = 0;
  int          n_tests = 0;

  always #4 pclk = ~pclk;

  // capsense input shares the far-side pin so both external paths count
  gst_timer gst_timer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_input(ext_clk), .cap_sense_osc(ext_clk),
    .crystal_in(xin), .crystal_out(xout), .crystal_osc_run(xrun),
    .gate_input(gsig[0]), .other_timer_overflow(gsig[1]),
    .comparator1_out(gsig[2]), .comparator2_out(gsig[3]),
    .special_event(sev), .sleep_mode(sleep), .overflow_flag(ovf),
    .wake_request(wake)
  );

  gst_ext_src gst_ext_src_inst (
    .pclk(pclk),
    .ext_clk(ext_clk)
  );

  // =====================================================================
  // report and compare
  task automatic summarize();
    $display("errors=%0d checks=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // =====================================================================
  // one apb transfer; an idle edge after it avoids double assignment
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k == 16) begin
      errors++;
      summarize();
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rv, {24'h0, e});
  endtask

  function automatic logic [7:0] cw(gst_src_t s, logic [1:0] p,
                                    logic o, logic b, logic r);
    return {s, p, o, b, 1'b0, r};
  endfunction

  // =====================================================================
  // scenario sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) rdc(12'(i * 4), 8'h00);
    xfer(1'b0, 12'h020, 8'h00);
    chk({31'h0, last_err}, 32'h1);
    xfer(1'b1, `GST_OFF_CTRL, 8'hfe);
    rdc(`GST_OFF_CTRL, 8'hfc);
    xfer(1'b1, `GST_OFF_CTRL, 8'h00);
    xfer(1'b1, `GST_OFF_COUNT_HIGH, 8'ha5);
    rdc(`GST_OFF_COUNT_HIGH, 8'ha5);
    // 17 pulses after a write: first rise skipped, then prescaled
    for (int b = 0; b < 2; b++) begin
      for (int p = 0; p < 4; p++) begin
        sleep <= (b == 1) && (p[0] == 1'b0);
        xfer(1'b1, `GST_OFF_CTRL, cw(p[0] ? GST_SRC_CAP : GST_SRC_EXT,
             2'(p), 1'b0, b[0], 1'b0));
        xfer(1'b1, `GST_OFF_COUNT_LOW, 8'h00);
        xfer(1'b1, `GST_OFF_COUNT_HIGH, 8'h00);
        xfer(1'b1, `GST_OFF_CTRL, cw(p[0] ? GST_SRC_CAP : GST_SRC_EXT,
             2'(p), 1'b0, b[0], 1'b1));
        gst_ext_src_inst.pulses(17);
        xfer(1'b1, `GST_OFF_CTRL, 8'h00);
        gst_ext_src_inst.pulses(3);
        rdc(`GST_OFF_COUNT_LOW, 8'(16 >> p));
      end
    end
    sleep <= 1'b0;
    // seven ticks left in the divide-by-8 stage must vanish on a write
    xfer(1'b1, `GST_OFF_CTRL, cw(GST_SRC_EXT, 2'd3, 1'b0, 1'b0, 1'b1));
    gst_ext_src_inst.pulses(8);
    xfer(1'b1, `GST_OFF_CTRL, 8'h00);
    xfer(1'b1, `GST_OFF_COUNT_LOW, 8'h00);
    xfer(1'b1, `GST_OFF_CTRL, cw(GST_SRC_EXT, 2'd3, 1'b0, 1'b0, 1'b1));
    gst_ext_src_inst.pulses(2);
    xfer(1'b1, `GST_OFF_CTRL, 8'h00);
    rdc(`GST_OFF_COUNT_LOW, 8'h00);
    // each gate source: counts when level matches, holds otherwise
    for (int g = 0; g < 4; g++) begin
      xfer(1'b1, `GST_OFF_GATE, {1'b1, g[0], 4'h0, 2'(g)});
      // even sources gate active low, odd ones active high
      gsig <= g[0] ? 4'(1 << g) : ~4'(1 << g);
      xfer(1'b1, `GST_OFF_COUNT_LOW, 8'h00);
      xfer(1'b1, `GST_OFF_CTRL, cw(GST_SRC_EXT, 2'd0, 1'b0, 1'b0, 1'b1));
      gst_ext_src_inst.pulses(5);
      gsig <= ~gsig;
      gst_ext_src_inst.pulses(5);
      xfer(1'b1, `GST_OFF_CTRL, 8'h00);
      rdc(`GST_OFF_COUNT_LOW, 8'h04);
    end
    xfer(1'b1, `GST_OFF_GATE, 8'h00);
    // instruction clock runs at a quarter of the system clock rate
    for (int s = 0; s < 2; s++) begin
      xfer(1'b1, `GST_OFF_COUNT_LOW, 8'h00);
      xfer(1'b1, `GST_OFF_CTRL, cw(gst_src_t'(s), 2'd0, 1'b0, 1'b0, 1'b1));
      repeat (40) @(posedge pclk);
      xfer(1'b1, `GST_OFF_CTRL, 8'h00);
      xfer(1'b0, `GST_OFF_COUNT_LOW, 8'h00);
      chk({31'h0, rv >= (s ? 40 : 9) && rv <= (s ? 46 : 12)}, 32'h1);
    end
    // rollover sets a sticky flag, cleared by writing one
    xfer(1'b1, `GST_OFF_COUNT_LOW, 8'hf0);
    xfer(1'b1, `GST_OFF_COUNT_HIGH, 8'hff);
    xfer(1'b1, `GST_OFF_CTRL, cw(GST_SRC_SYS, 2'd0, 1'b0, 1'b0, 1'b1));
    for (int k = 0; k < 100 && ovf !== 1'b1; k++) @(posedge pclk);
    xfer(1'b1, `GST_OFF_CTRL, 8'h00);
    rdc(`GST_OFF_STATUS, 8'h01);
    // overflow flag still set on entering sleep asks for a wake-up
    sleep <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({30'h0, wake, ovf}, 32'h3);
    sleep <= 1'b0;
    xfer(1'b1, `GST_OFF_STATUS, 8'h01);
    rdc(`GST_OFF_STATUS, 8'h00);
    chk({30'h0, wake, ovf}, 32'h0);
    // special event clears the count without flagging overflow
    xfer(1'b1, `GST_OFF_COUNT_HIGH, 8'h12);
    sev <= 1'b1;
    @(posedge pclk);
    sev <= 1'b0;
    @(posedge pclk);
    rdc(`GST_OFF_COUNT_HIGH, 8'h00);
    rdc(`GST_OFF_STATUS, 8'h00);
    // a write without the low byte strobe is dropped
    pstrb <= 4'he;
    xfer(1'b1, `GST_OFF_COUNT_LOW, 8'h55);
    pstrb <= 4'hf;
    rdc(`GST_OFF_COUNT_LOW, 8'h00);
    // oscillator enable; software allows start-up before use
    xfer(1'b1, `GST_OFF_CTRL, cw(GST_SRC_EXT, 2'd0, 1'b1, 1'b0, 1'b0));
    chk({31'h0, xrun}, 32'h1);
    repeat (20) @(posedge pclk);
    chk({31'h0, xout}, 32'h1);
    xin <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0, xout}, 32'h0);
    xin <= 1'b0;
    // crystal pin is the count source under 10 with the oscillator on
    xfer(1'b1, `GST_OFF_COUNT_LOW, 8'h00);
    xfer(1'b1, `GST_OFF_CTRL, cw(GST_SRC_EXT, 2'd0, 1'b1, 1'b0, 1'b1));
    for (int n = 0; n < 5; n++) begin
      repeat (4) @(posedge pclk);
      xin <= 1'b1;
      repeat (4) @(posedge pclk);
      xin <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    xfer(1'b1, `GST_OFF_CTRL, 8'h00);
    rdc(`GST_OFF_COUNT_LOW, 8'h04);
    summarize();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    summarize();
  end
endmodule
`default_nettype wire
